// ---- ppafm_consts.svh ----
// Register offsets, field positions and reset values of the port pin block
`ifndef PPAFM_CONSTS_SVH
`define PPAFM_CONSTS_SVH
`define PPAFM_NPINS 18
`define PPAFM_A_LO 0
`define PPAFM_B_LO 4
`define PPAFM_C_LO 6
`define PPAFM_D_LO 10
`define PPAFM_E_LO 12
`define PPAFM_OFS_A_DATA 8'h00
`define PPAFM_OFS_A_DIR 8'h04
`define PPAFM_OFS_B_DATA 8'h08
`define PPAFM_OFS_B_DIR 8'h0c
`define PPAFM_OFS_C_DATA 8'h10
`define PPAFM_OFS_C_DIR 8'h14
`define PPAFM_OFS_D_DATA 8'h18
`define PPAFM_OFS_D_DIR 8'h1c
`define PPAFM_OFS_PULLUP 8'h20
`define PPAFM_OFS_KEYMODE 8'h24
`define PPAFM_OFS_D_CTRL 8'h28
`define PPAFM_OFS_EDGE 8'h2c
`define PPAFM_OFS_E_FUNC 8'h30
`define PPAFM_OFS_E_DATA 8'h34
`define PPAFM_OFS_IRQ_STAT 8'h38
`define PPAFM_OFS_IRQ_CLR 8'h3c
`define PPAFM_OFS_IRQ_EN 8'h40
`define PPAFM_PU_A_BIT 0
`define PPAFM_PU_B_BIT 1
`define PPAFM_PU_C_BIT 2
`define PPAFM_CTRL_TIMER_BIT 0
`define PPAFM_CTRL_INTAN_BIT 1
`define PPAFM_EDGE_RISE_BIT 0
`define PPAFM_EDGE_FALL_BIT 1
`define PPAFM_IRQ_EXT_BIT 0
`define PPAFM_IRQ_KEY_BIT 1
`define PPAFM_RST_ZERO 32'h0000_0000
`define PPAFM_COM_LOW_RST 3'h0
`endif

// ---- ppafm_pkg.sv ----
// Types shared by the port pin block
package ppafm_pkg;
  typedef logic [31:0] ppafm_word_t;
  typedef logic [7:0] ppafm_addr_t;
  typedef enum logic [1:0] {
    PPAFM_OKAY = 2'h0,
    PPAFM_SLVERR = 2'h2
  } ppafm_resp_e;
endpackage

// ---- ppafm_sync_if.sv ----
// Raw pin levels and their synchronised copies
`timescale 1ns/1ps
`include "ppafm_consts.svh"
interface ppafm_sync_if;
  logic [`PPAFM_NPINS-1:0] raw;
  logic [`PPAFM_NPINS-1:0] sync;
  modport src (output raw, input sync);
  modport dst (input raw, output sync);
endinterface

// ---- ppafm_sync.sv ----
// Two-stage synchroniser for all pin inputs
`timescale 1ns/1ps
`include "ppafm_consts.svh"
module ppafm_sync import ppafm_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  ppafm_sync_if.dst pins
);
  logic [`PPAFM_NPINS-1:0] meta_reg;
  logic [`PPAFM_NPINS-1:0] sync_reg;

  // First stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= pins.raw;
      sync_reg <= meta_reg;
    end
  end

  assign pins.sync = sync_reg;
endmodule

// ---- ppafm_top.sv ----
// Port pins with alternate functions, AXI4-Lite register slave
// How it works
// - Port A four pins, per-bit direction
// - Port-wide pull-ups on A, B, C inputs only
// - Port B two pins, per-bit direction
// - Port C per bit: port or key-return input
// - Port C pull-up by pull-up or key register
// - Port D: timer out, interrupt/analog in
// - Interrupt edge: rising, falling or both
// - Port E inputs or reversed LCD segments
// - After reset commons, segments low; flash COM3 high
// - Reset input is active low
`timescale 1ns/1ps
`include "ppafm_consts.svh"
module ppafm_top import ppafm_pkg::*; #(
  parameter bit FLASH_PART = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] port_a_pins_i,
  output logic [3:0] port_a_pins_o,
  output logic [3:0] port_a_pins_oe,
  output logic [3:0] port_a_pullup,
  input wire logic [1:0] port_b_pins_i,
  output logic [1:0] port_b_pins_o,
  output logic [1:0] port_b_pins_oe,
  output logic [1:0] port_b_pullup,
  input wire logic [3:0] port_c_pins_i,
  output logic [3:0] port_c_pins_o,
  output logic [3:0] port_c_pins_oe,
  output logic [3:0] port_c_pullup,
  output logic [3:0] key_return_inputs,
  input wire logic port_d_pin_zero_i,
  output logic port_d_pin_zero_o,
  output logic port_d_pin_zero_oe,
  input wire logic port_d_pin_one_i,
  output logic port_d_pin_one_o,
  output logic port_d_pin_one_oe,
  input wire logic timer_out,
  output logic ext_interrupt_in,
  output logic analog_in_sel,
  input wire logic [5:0] port_e_input_pins_i,
  output logic [5:0] port_e_input_pins_o,
  output logic [5:0] port_e_input_pins_oe,
  input wire logic [5:0] lcd_segment_shared,
  input wire logic [16:0] lcd_segment_data,
  input wire logic [3:0] lcd_common_data,
  output logic [16:0] lcd_segment_dedicated,
  output logic [3:0] lcd_common_outputs,
  output logic irq
);
  ppafm_sync_if pins_if ();
  logic [3:0] a_lat_reg, a_dir_reg, c_lat_reg, c_dir_reg, key_mode_reg;
  logic [1:0] b_lat_reg, b_dir_reg, d_lat_reg, d_dir_reg, d_ctrl_reg, edge_reg;
  logic [2:0] pullup_reg;
  logic [5:0] e_func_reg;
  logic [1:0] irq_stat_reg, irq_en_reg, irq_stat_next, irq_clr, irq_ev;
  logic [3:0] key_prev_reg;
  logic ext_prev_reg, aw_have_reg, w_have_reg;
  ppafm_addr_t aw_addr_reg;
  logic [7:0] w_data_reg;
  logic w_lane_reg, wr_fire, wr_hit, rd_hit;
  ppafm_word_t rd_word;
  logic [`PPAFM_NPINS-1:0] s;

  // Every pin input is synchronised before use
  assign pins_if.raw = {port_e_input_pins_i, port_d_pin_one_i, port_d_pin_zero_i,
                        port_c_pins_i, port_b_pins_i, port_a_pins_i};
  assign s = pins_if.sync;
  ppafm_sync u_sync (.aclk(aclk), .aresetn(aresetn), .pins(pins_if.dst));

  // Write address and data are taken independently
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_lane_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PPAFM_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_lane_reg <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? PPAFM_OKAY : PPAFM_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
  assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;

  // Address decode of writes
  always_comb begin
    unique case (aw_addr_reg)
      `PPAFM_OFS_A_DATA, `PPAFM_OFS_A_DIR, `PPAFM_OFS_B_DATA, `PPAFM_OFS_B_DIR,
      `PPAFM_OFS_C_DATA, `PPAFM_OFS_C_DIR, `PPAFM_OFS_D_DATA, `PPAFM_OFS_D_DIR,
      `PPAFM_OFS_PULLUP, `PPAFM_OFS_KEYMODE, `PPAFM_OFS_D_CTRL, `PPAFM_OFS_EDGE,
      `PPAFM_OFS_E_FUNC, `PPAFM_OFS_IRQ_CLR, `PPAFM_OFS_IRQ_EN: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Control registers; all pins start as inputs in port mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      a_lat_reg <= '0; a_dir_reg <= '0;
      b_lat_reg <= '0; b_dir_reg <= '0;
      c_lat_reg <= '0; c_dir_reg <= '0;
      d_lat_reg <= '0; d_dir_reg <= '0;
      pullup_reg <= '0; key_mode_reg <= '0;
      d_ctrl_reg <= '0; edge_reg <= '0;
      e_func_reg <= '0; irq_en_reg <= '0;
    end else if (wr_fire && w_lane_reg) begin
      unique case (aw_addr_reg)
        `PPAFM_OFS_A_DATA: a_lat_reg <= w_data_reg[3:0];
        `PPAFM_OFS_A_DIR: a_dir_reg <= w_data_reg[3:0];
        `PPAFM_OFS_B_DATA: b_lat_reg <= w_data_reg[1:0];
        `PPAFM_OFS_B_DIR: b_dir_reg <= w_data_reg[1:0];
        `PPAFM_OFS_C_DATA: c_lat_reg <= w_data_reg[3:0];
        `PPAFM_OFS_C_DIR: c_dir_reg <= w_data_reg[3:0];
        `PPAFM_OFS_D_DATA: d_lat_reg <= w_data_reg[1:0];
        `PPAFM_OFS_D_DIR: d_dir_reg <= w_data_reg[1:0];
        `PPAFM_OFS_PULLUP: pullup_reg <= w_data_reg[2:0];
        `PPAFM_OFS_KEYMODE: key_mode_reg <= w_data_reg[3:0];
        `PPAFM_OFS_D_CTRL: d_ctrl_reg <= w_data_reg[1:0];
        `PPAFM_OFS_EDGE: edge_reg <= w_data_reg[1:0];
        `PPAFM_OFS_E_FUNC: e_func_reg <= w_data_reg[5:0];
        `PPAFM_OFS_IRQ_EN: irq_en_reg <= w_data_reg[1:0];
        default: ;
      endcase
    end
  end

  // Read data mux; bits with direction set read the latch, others the pin
  always_comb begin
    rd_word = `PPAFM_RST_ZERO;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      `PPAFM_OFS_A_DATA: rd_word[3:0] = (a_dir_reg & a_lat_reg) |
                                        (~a_dir_reg & s[`PPAFM_A_LO +: 4]);
      `PPAFM_OFS_A_DIR: rd_word[3:0] = a_dir_reg;
      `PPAFM_OFS_B_DATA: rd_word[1:0] = (b_dir_reg & b_lat_reg) |
                                        (~b_dir_reg & s[`PPAFM_B_LO +: 2]);
      `PPAFM_OFS_B_DIR: rd_word[1:0] = b_dir_reg;
      `PPAFM_OFS_C_DATA: rd_word[3:0] = (c_dir_reg & c_lat_reg) |
                                        (~c_dir_reg & s[`PPAFM_C_LO +: 4]);
      `PPAFM_OFS_C_DIR: rd_word[3:0] = c_dir_reg;
      `PPAFM_OFS_D_DATA: rd_word[1:0] = (d_dir_reg & d_lat_reg) |
                                        (~d_dir_reg & s[`PPAFM_D_LO +: 2]);
      `PPAFM_OFS_D_DIR: rd_word[1:0] = d_dir_reg;
      `PPAFM_OFS_PULLUP: rd_word[2:0] = pullup_reg;
      `PPAFM_OFS_KEYMODE: rd_word[3:0] = key_mode_reg;
      `PPAFM_OFS_D_CTRL: rd_word[1:0] = d_ctrl_reg;
      `PPAFM_OFS_EDGE: rd_word[1:0] = edge_reg;
      `PPAFM_OFS_E_FUNC: rd_word[5:0] = e_func_reg;
      `PPAFM_OFS_E_DATA: rd_word[5:0] = s[`PPAFM_E_LO +: 6];
      `PPAFM_OFS_IRQ_STAT: rd_word[1:0] = irq_stat_reg;
      `PPAFM_OFS_IRQ_CLR: rd_word[1:0] = 2'h0;
      `PPAFM_OFS_IRQ_EN: rd_word[1:0] = irq_en_reg;
      default: rd_hit = 1'b0;
    endcase
  end

  // Read channel: one read in flight, answered the cycle after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `PPAFM_RST_ZERO;
      s_axi_rresp <= PPAFM_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? PPAFM_OKAY : PPAFM_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;

  // Edge and key-return event detection on synchronised levels
  always_comb begin
    irq_ev[`PPAFM_IRQ_EXT_BIT] = d_ctrl_reg[`PPAFM_CTRL_INTAN_BIT] &&
      ((edge_reg[`PPAFM_EDGE_RISE_BIT] && s[`PPAFM_D_LO+1] && !ext_prev_reg) ||
       (edge_reg[`PPAFM_EDGE_FALL_BIT] && !s[`PPAFM_D_LO+1] && ext_prev_reg));
    irq_ev[`PPAFM_IRQ_KEY_BIT] = |(key_mode_reg & key_prev_reg & ~s[`PPAFM_C_LO +: 4]);
    irq_clr = (wr_fire && w_lane_reg && aw_addr_reg == `PPAFM_OFS_IRQ_CLR) ?
              w_data_reg[1:0] : 2'h0;
    irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_ev; // Set wins over clear
  end

  // Sticky status and interrupt output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_prev_reg <= 1'b0;
      key_prev_reg <= '0;
      irq_stat_reg <= '0;
      irq <= 1'b0;
    end else begin
      ext_prev_reg <= s[`PPAFM_D_LO+1];
      key_prev_reg <= s[`PPAFM_C_LO +: 4];
      irq_stat_reg <= irq_stat_next;
      irq <= |(irq_stat_next & irq_en_reg);
    end
  end

  // Pin drivers, pull-ups and alternate-function muxing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_a_pins_o <= '0; port_a_pins_oe <= '0; port_a_pullup <= '0;
      port_b_pins_o <= '0; port_b_pins_oe <= '0; port_b_pullup <= '0;
      port_c_pins_o <= '0; port_c_pins_oe <= '0; port_c_pullup <= '0;
      key_return_inputs <= '0;
      port_d_pin_zero_o <= 1'b0; port_d_pin_zero_oe <= 1'b0;
      port_d_pin_one_o <= 1'b0; port_d_pin_one_oe <= 1'b0;
      ext_interrupt_in <= 1'b0; analog_in_sel <= 1'b0;
      port_e_input_pins_o <= '0; port_e_input_pins_oe <= '0;
    end else begin
      port_a_pins_o <= a_lat_reg;
      port_a_pins_oe <= a_dir_reg;
      port_a_pullup <= {4{pullup_reg[`PPAFM_PU_A_BIT]}} & ~a_dir_reg;
      port_b_pins_o <= b_lat_reg;
      port_b_pins_oe <= b_dir_reg;
      port_b_pullup <= {2{pullup_reg[`PPAFM_PU_B_BIT]}} & ~b_dir_reg;
      port_c_pins_o <= c_lat_reg;
      port_c_pins_oe <= c_dir_reg & ~key_mode_reg;
      port_c_pullup <= {4{pullup_reg[`PPAFM_PU_C_BIT] | (|key_mode_reg)}} &
                       ~(c_dir_reg & ~key_mode_reg);
      key_return_inputs <= key_mode_reg & s[`PPAFM_C_LO +: 4];
      port_d_pin_zero_o <= d_ctrl_reg[`PPAFM_CTRL_TIMER_BIT] ? timer_out : d_lat_reg[0];
      port_d_pin_zero_oe <= d_ctrl_reg[`PPAFM_CTRL_TIMER_BIT] | d_dir_reg[0];
      port_d_pin_one_o <= d_lat_reg[1];
      port_d_pin_one_oe <= !d_ctrl_reg[`PPAFM_CTRL_INTAN_BIT] && d_dir_reg[1];
      ext_interrupt_in <= d_ctrl_reg[`PPAFM_CTRL_INTAN_BIT] && s[`PPAFM_D_LO+1];
      analog_in_sel <= d_ctrl_reg[`PPAFM_CTRL_INTAN_BIT];
      for (int k = 0; k < 6; k++) begin
        port_e_input_pins_o[k] <= lcd_segment_shared[5-k];
      end
      port_e_input_pins_oe <= e_func_reg;
    end
  end

  // LCD dedicated outputs; fourth common resets by part type
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lcd_segment_dedicated <= '0;
      lcd_common_outputs <= {FLASH_PART, `PPAFM_COM_LOW_RST};
    end else begin
      lcd_segment_dedicated <= lcd_segment_data;
      lcd_common_outputs <= lcd_common_data;
    end
  end

  // Checks of pin behaviour
  AST_RESET_INPUTS: assert property (@(posedge aclk) $rose(aresetn) |->
    (port_a_pins_oe == 4'h0 && port_b_pins_oe == 2'h0 && port_c_pins_oe == 4'h0 &&
     !port_d_pin_zero_oe && !port_d_pin_one_oe && port_e_input_pins_oe == 6'h00))
    else $error("Pin driving right after reset");
  AST_RESET_LCD: assert property (@(posedge aclk) $rose(aresetn) |->
    (lcd_segment_dedicated == 17'h00000 && lcd_common_outputs == {FLASH_PART, 3'h0}))
    else $error("LCD outputs wrong after reset");
  AST_A_DIR: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> port_a_pins_oe == $past(a_dir_reg))
    else $error("Port A enable does not follow direction");
  AST_B_DIR: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> port_b_pins_oe == $past(b_dir_reg))
    else $error("Port B enable does not follow direction");
  AST_A_PULL: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> port_a_pullup == ({4{$past(pullup_reg[0])}} & ~$past(a_dir_reg)))
    else $error("Port A pull-up wrong");
  AST_C_KEY: assert property (@(posedge aclk) disable iff (!aresetn)
    key_mode_reg != 4'h0 |=> (port_c_pins_oe & $past(key_mode_reg)) == 4'h0)
    else $error("Key-return pin driven");
  AST_C_PULL: assert property (@(posedge aclk) disable iff (!aresetn)
    (key_mode_reg != 4'h0 && c_dir_reg == 4'h0) |=> port_c_pullup == 4'hf)
    else $error("Port C pull-up missing in key mode");
  AST_TIMER: assert property (@(posedge aclk) disable iff (!aresetn)
    d_ctrl_reg[0] |=> (port_d_pin_zero_oe && port_d_pin_zero_o == $past(timer_out)))
    else $error("Timer output not on pin");
  AST_EDGE: assert property (@(posedge aclk) disable iff (!aresetn)
    (d_ctrl_reg[1] && edge_reg == 2'h1 && s[11] && !ext_prev_reg) |=> irq_stat_reg[0])
    else $error("Rising edge not captured");
  AST_SEG: assert property (@(posedge aclk) disable iff (!aresetn)
    e_func_reg[0] |=> (port_e_input_pins_oe[0] &&
                       port_e_input_pins_o[0] == $past(lcd_segment_shared[5])))
    else $error("Segment order wrong");
  AST_RESET_LOW: assert property (@(posedge aclk) !aresetn |=> !irq)
    else $error("Interrupt high after reset");
  COV_EXT: cover property (@(posedge aclk) disable iff (!aresetn) irq_ev[0]);
  COV_KEY: cover property (@(posedge aclk) disable iff (!aresetn) irq_ev[1]);
  COV_IRQ: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
  COV_WR: cover property (@(posedge aclk) disable iff (!aresetn) wr_fire && wr_hit);
endmodule

// ---- ppafm_board.sv ----
// Board-side model of the port pins: external drivers, pull-ups and floating lines
`timescale 1ns/1ps
module ppafm_board #(
  parameter int W = 4
) (
  input wire logic aclk,
  input wire logic [W-1:0] dev_o,
  input wire logic [W-1:0] dev_oe,
  input wire logic [W-1:0] pull,
  input wire logic [W-1:0] ext_val,
  input wire logic [W-1:0] ext_en,
  output logic [W-1:0] level
);
  logic [W-1:0] flt_reg = '0;
  // A released pin with no pull-up wanders every cycle, so stale values are never seen
  always_ff @(posedge aclk) begin
    flt_reg <= ~level;
  end
  // Device driver wins, then the board driver, then the pull-up
  always_comb begin
    for (int k = 0; k < W; k++) begin
      level[k] = dev_oe[k] ? dev_o[k] : ext_en[k] ? ext_val[k] : pull[k] ? 1'b1 : flt_reg[k];
    end
  end
endmodule

// ---- ppafm_test.sv ----
// Self-checking bench for the port pin block, with a board model on every pin
`timescale 1ns/1ps
`include "ppafm_consts.svh"
module ppafm_test import ppafm_pkg::*; ;
  localparam bit FLASH = 1'b1;
  localparam logic [1:0] OK = PPAFM_OKAY;
  localparam logic [1:0] ERR = PPAFM_SLVERR;
  logic aclk = 1'b0, aresetn = 1'b0, tmr = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hf, a_i, a_o, a_oe, a_pu, c_i, c_o, c_oe, c_pu, kr, com, comd = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, d0_o, d0_oe, d1_o, d1_oe, eint, ana, irq;
  logic [1:0] bresp, rresp, b_i, b_o, b_oe, b_pu, d_i;
  logic [5:0] e_i, e_o, e_oe, seg6 = 6'h0;
  logic [16:0] segd = 17'h0, seg;
  logic [17:0] xv = 18'h0, xe = 18'h0;
  logic [7:0] bpu = 8'h00;
  logic main_osc_out = 1'b1, sub_osc_in = 1'b0, sub_osc_out = 1'b1;
  int n_fail = 0, n_compared = 0, cyc = 0, seed;

  ppafm_top #(.FLASH_PART(FLASH)) uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .port_a_pins_i(a_i), .port_a_pins_o(a_o), .port_a_pins_oe(a_oe), .port_a_pullup(a_pu),
    .port_b_pins_i(b_i), .port_b_pins_o(b_o), .port_b_pins_oe(b_oe), .port_b_pullup(b_pu),
    .port_c_pins_i(c_i), .port_c_pins_o(c_o), .port_c_pins_oe(c_oe), .port_c_pullup(c_pu),
    .key_return_inputs(kr), .port_d_pin_zero_i(d_i[0]), .port_d_pin_zero_o(d0_o),
    .port_d_pin_zero_oe(d0_oe), .port_d_pin_one_i(d_i[1]), .port_d_pin_one_o(d1_o),
    .port_d_pin_one_oe(d1_oe), .timer_out(tmr), .ext_interrupt_in(eint),
    .analog_in_sel(ana), .port_e_input_pins_i(e_i), .port_e_input_pins_o(e_o),
    .port_e_input_pins_oe(e_oe), .lcd_segment_shared(seg6), .lcd_segment_data(segd),
    .lcd_common_data(comd), .lcd_segment_dedicated(seg), .lcd_common_outputs(com), .irq(irq));

  // Board circuitry on each port
  ppafm_board #(.W(4)) brd_a (.aclk(aclk), .dev_o(a_o), .dev_oe(a_oe), .pull(a_pu),
    .ext_val(xv[3:0]), .ext_en(xe[3:0]), .level(a_i));
  ppafm_board #(.W(2)) brd_b (.aclk(aclk), .dev_o(b_o), .dev_oe(b_oe), .pull(b_pu),
    .ext_val(xv[5:4]), .ext_en(xe[5:4]), .level(b_i));
  ppafm_board #(.W(4)) brd_c (.aclk(aclk), .dev_o(c_o), .dev_oe(c_oe), .pull(c_pu),
    .ext_val(xv[9:6]), .ext_en(xe[9:6]), .level(c_i));
  ppafm_board #(.W(2)) brd_d (.aclk(aclk), .dev_o({d1_o, d0_o}), .dev_oe({d1_oe, d0_oe}),
    .pull(bpu[1:0]), .ext_val(xv[11:10]), .ext_en(xe[11:10]), .level(d_i));
  ppafm_board #(.W(6)) brd_e (.aclk(aclk), .dev_o(e_o), .dev_oe(e_oe), .pull(bpu[7:2]),
    .ext_val(xv[17:12]), .ext_en(xe[17:12]), .level(e_i));

  // Clock and hang guard
  always #5 begin
    main_osc_out = aclk;
    aclk = ~aclk;
  end
  // Slow external sub clock, fed true and inverted
  always #35 begin
    sub_osc_out = sub_osc_in;
    sub_osc_in = ~sub_osc_in;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("TB: %0d compared, %0d failed", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // One register write; address and data offered together, each released when taken
  task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er = 2'h0);
    logic ta = 1'b0, tw = 1'b0, ga, gw;
    @(posedge aclk);
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(negedge aclk);
      ga = awvalid && awready;
      gw = wvalid && wready;
      @(posedge aclk);
      if (ga) awvalid <= 1'b0;
      if (gw) wvalid <= 1'b0;
      ta = ta | ga;
      tw = tw | gw;
    end while (!(ta && tw));
    bready <= 1'b1;
    do @(negedge aclk); while (bvalid !== 1'b1);
    chk("bresp", bresp, er);
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  // One register read; data and response sampled at the falling edge before the handshake edge
  task automatic rd(input logic [7:0] ad, output logic [31:0] d, input logic [1:0] er = 2'h0);
    @(posedge aclk);
    araddr <= ad;
    arvalid <= 1'b1;
    do @(negedge aclk); while (!(arvalid && arready));
    @(posedge aclk);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(negedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    chk("rresp", rresp, er);
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  // Let n edges pass, then settle at the falling edge for sampling
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask

  function automatic logic [5:0] rev6(input logic [5:0] x);
    for (int k = 0; k < 6; k++) begin
      rev6[k] = x[5 - k];
    end
  endfunction
  function automatic logic [3:0] oe_of(input int p);
    oe_of = p == 0 ? a_oe : p == 1 ? {2'b00, b_oe} : c_oe;
  endfunction
  function automatic logic [3:0] out_of(input int p);
    out_of = p == 0 ? a_o : p == 1 ? {2'b00, b_o} : c_o;
  endfunction
  function automatic logic [3:0] pu_of(input int p);
    pu_of = p == 0 ? a_pu : p == 1 ? {2'b00, b_pu} : c_pu;
  endfunction

  initial begin
    logic [7:0] ofs, zr [11];
    logic [31:0] r, dir, dat, v, m;
    zr = '{8'h04, 8'h0c, 8'h14, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h38, 8'h40};
    seed = 32'h7bbe;
    segd = 17'h1ffff;
    comd = 4'hf;
    // Reset holds outputs at their reset levels whatever the LCD logic asks
    wt(11);
    chk("lcd", {seg, com}, {17'h0, FLASH, 3'h0});
    chk("oe", {a_oe, b_oe, c_oe, d1_oe, d0_oe, e_oe, irq}, 0);
    chk("osc pair", {main_osc_out ^ aclk, sub_osc_out ^ sub_osc_in}, 2'b11);
    @(posedge aclk);
    aresetn <= 1'b1;
    foreach (zr[i]) begin
      rd(zr[i], r);
      chk("reset value", r, 0);
    end
    rd(8'h44, r, ERR);
    chk("unmapped read", r, 0);
    wr(8'h80, 32'h1, ERR);
    // A write without byte lane 0 changes nothing
    wstrb <= 4'he;
    wr(`PPAFM_OFS_A_DIR, 32'hf);
    wstrb <= 4'hf;
    rd(`PPAFM_OFS_A_DIR, r);
    chk("lane off", r, 0);
    // Ports A, B, C: random direction, latch and board levels, then pull-ups
    for (int p = 0; p < 3; p++) begin
      ofs = p == 0 ? `PPAFM_OFS_A_DATA : p == 1 ? `PPAFM_OFS_B_DATA : `PPAFM_OFS_C_DATA;
      m = p == 1 ? 32'h3 : 32'hf;
      repeat (4) begin
        dir = $random(seed) & m;
        dat = $random(seed) & m;
        v = $random(seed);
        @(posedge aclk);
        xv <= v[17:0];
        xe <= 18'h3ffff;
        wr(ofs + 8'h04, dir);
        wr(ofs, dat);
        rd(ofs, r);
        chk("port read", r, ((dir & dat) | (~dir & (v >> (p * 4 - (p / 2) * 2)))) & m);
        wt(0);
        chk("port oe", oe_of(p), dir);
        chk("port out", out_of(p) & dir, dat & dir);
      end
      @(posedge aclk);
      xe <= 18'h0;
      wr(`PPAFM_OFS_PULLUP, 32'h1 << p);
      wt(2);
      rd(ofs, r);
      chk("pulled read", r & ~dir, ~dir & m);
      chk("pullup", pu_of(p), ~dir & m);
      wr(`PPAFM_OFS_PULLUP, 32'h0);
    end
    // Port C key-return mode on pins 0 and 2 while all four are set as outputs
    @(posedge aclk);
    xe <= 18'h3ffff;
    xv[6] <= 1'b1;
    wr(`PPAFM_OFS_C_DIR, 32'hf);
    wr(`PPAFM_OFS_C_DATA, 32'hf);
    wr(`PPAFM_OFS_KEYMODE, 32'h5);
    wt(4);
    chk("key oe", c_oe, 4'ha);
    chk("key pullup", c_pu, 4'h5);
    chk("key inputs", kr, {1'b0, xv[8], 1'b0, 1'b1});
    wr(`PPAFM_OFS_IRQ_CLR, 32'h3);
    wr(`PPAFM_OFS_IRQ_EN, 32'h3);
    @(posedge aclk);
    xv[6] <= 1'b0;
    wt(3);
    rd(`PPAFM_OFS_IRQ_STAT, r);
    chk("key status", r, 32'h2);
    wt(0);
    chk("irq", irq, 1'b1);
    wr(`PPAFM_OFS_IRQ_EN, 32'h0);
    wt(0);
    chk("masked irq", irq, 1'b0);
    wr(`PPAFM_OFS_IRQ_CLR, 32'h2);
    rd(`PPAFM_OFS_IRQ_STAT, r);
    chk("cleared status", r, 32'h0);
    wr(`PPAFM_OFS_KEYMODE, 32'h0);
    // Port D: timer output on pin 0, interrupt and analog input on pin 1
    wr(`PPAFM_OFS_D_DIR, 32'h3);
    wr(`PPAFM_OFS_D_DATA, 32'h2);
    wr(`PPAFM_OFS_D_CTRL, 32'h1);
    for (int t = 1; t >= 0; t--) begin
      @(posedge aclk);
      tmr <= t[0];
      wt(3);
      chk("timer pin", {d0_oe, d0_o, d1_oe, d1_o}, {1'b1, t[0], 2'b11});
    end
    @(posedge aclk);
    xv[11] <= 1'b0;
    wr(`PPAFM_OFS_D_CTRL, 32'h3);
    wr(`PPAFM_OFS_IRQ_EN, 32'h1);
    wt(0);
    chk("ctrl pin one", {d1_oe, ana}, 2'b01);
    for (int e = 1; e < 4; e++) begin
      wr(`PPAFM_OFS_EDGE, e);
      for (int lv = 1; lv >= 0; lv--) begin
        wr(`PPAFM_OFS_IRQ_CLR, 32'h3);
        @(posedge aclk);
        xv[11] <= lv[0];
        wt(5);
        chk("ext in", eint, lv[0]);
        chk("edge irq", irq, lv ? e[0] : e[1]);
        rd(`PPAFM_OFS_IRQ_STAT, r);
        chk("edge status", r, lv ? e[0] : e[1]);
      end
    end
    // Port E: random split between inputs and reversed segment outputs
    repeat (4) begin
      v = $random(seed);
      @(posedge aclk);
      seg6 <= v[5:0];
      xv[17:12] <= v[11:6];
      wr(`PPAFM_OFS_E_FUNC, v[17:12]);
      wt(2);
      rd(`PPAFM_OFS_E_DATA, r);
      chk("E read", r & ~v[17:12], {26'h0, v[11:6] & ~v[17:12]});
      wt(2);
      chk("E oe", e_oe, v[17:12]);
      chk("E seg", e_o & v[17:12], rev6(v[5:0]) & v[17:12]);
    end
    // Released port E pins with board pull-ups read high
    @(posedge aclk);
    xe[17:12] <= 6'h00;
    bpu <= 8'hfc;
    wr(`PPAFM_OFS_E_FUNC, 32'h0);
    wt(3);
    rd(`PPAFM_OFS_E_DATA, r);
    chk("E pulled", r, 32'h3f);
    // Dedicated LCD outputs follow the LCD logic after reset
    v = $random(seed);
    @(posedge aclk);
    segd <= v[16:0];
    comd <= 4'h6;
    wt(3);
    chk("lcd follow", {seg, com}, {segd, comd});
    // Reset in mid-run releases every pin driver again
    @(posedge aclk);
    aresetn <= 1'b0;
    wt(3);
    chk("oe rst", {a_oe, b_oe, c_oe, d1_oe, d0_oe, e_oe, com}, {FLASH, 3'h0});
    @(posedge aclk);
    aresetn <= 1'b1;
    rd(`PPAFM_OFS_D_CTRL, r);
    chk("ctrl after reset", r, 0);
    report_and_stop();
  end
endmodule
